// ### logic/data_eeprom_access_control.sv
// Data EEPROM access control: move routing, page buffer, programming and AXI4-Lite registers
//
// Design decisions made here: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module data_eeprom_access_control #(
  parameter int unsigned PROG_CYCLES = eeprom_ctl_pkg::PROG_CYCLES_DEFAULT
) (
  input  wire logic                        ref_clk_in,
  input  wire logic                        reset_in,
  input  wire logic                        s_axi_awvalid_in,
  output logic                             s_axi_awready_out,
  input  wire logic [31:0]                 s_axi_awaddr_in,
  input  wire logic                        s_axi_wvalid_in,
  output logic                             s_axi_wready_out,
  input  wire logic [31:0]                 s_axi_wdata_in,
  input  wire logic [3:0]                  s_axi_wstrb_in,
  output logic                             s_axi_bvalid_out,
  input  wire logic                        s_axi_bready_in,
  output logic      [1:0]                  s_axi_bresp_out,
  input  wire logic                        s_axi_arvalid_in,
  output logic                             s_axi_arready_out,
  input  wire logic [31:0]                 s_axi_araddr_in,
  output logic                             s_axi_rvalid_out,
  input  wire logic                        s_axi_rready_in,
  output logic      [31:0]                 s_axi_rdata_out,
  output logic      [1:0]                  s_axi_rresp_out,
  input  wire logic                        move_valid_in,
  output logic                             move_ready_out,
  input  wire eeprom_ctl_pkg::move_req_type move_req_in,
  output logic                             move_ack_out,
  output logic      [7:0]                  move_rdata_out,
  output eeprom_ctl_pkg::ext_bus_type      ext_bus_out,
  input  wire logic [7:0]                  ext_rdata_in,
  input  wire logic                        supply_ok_in,
  output logic                             irq_out
);
  typedef struct packed {
    logic                                    page_load;
    logic                                    write_en;
    logic                                    onchip_sel;
    logic                                    bank_sel;
    logic                                    ready;
    logic                                    supply_s1;
    logic                                    supply_s2;
    logic [eeprom_ctl_pkg::PTR_W-1:0]        dp0;
    logic [eeprom_ctl_pkg::PTR_W-1:0]        dp1;
    eeprom_ctl_pkg::nv_state_type            state;
    logic [31:0]                             timer;
    logic [eeprom_ctl_pkg::PAGE_BYTES*8-1:0] buf_data;
    logic [eeprom_ctl_pkg::PAGE_BYTES-1:0]   buf_valid;
    logic [eeprom_ctl_pkg::PAGE_NUM_W-1:0]   buf_page;
    logic [eeprom_ctl_pkg::PAGE_OFF_W-1:0]   commit_idx;
    logic                                    pend;
    logic                                    pend_onchip;
    logic                                    pend_inv;
    logic [7:0]                              pend_byte;
    logic                                    ack;
    logic [7:0]                              rdata;
    eeprom_ctl_pkg::ext_bus_type             ext;
    logic                                    aw_full;
    logic [7:0]                              aw_addr;
    logic                                    w_full;
    logic [31:0]                             w_data;
    logic [3:0]                              w_strb;
    logic                                    bvalid;
    logic [1:0]                              bresp;
    logic                                    rvalid;
    logic [31:0]                             axi_rdata;
    logic [1:0]                              rresp;
    logic [eeprom_ctl_pkg::IRQ_W-1:0]        irq_status;
    logic [eeprom_ctl_pkg::IRQ_W-1:0]        irq_mask;
  } state_type;

  state_type s_reg;
  state_type s_next;

  logic [eeprom_ctl_pkg::PTR_W-1:0]     active_ptr;
  logic [7:0]                           mem_rdata;
  logic                                 mem_we;
  logic [eeprom_ctl_pkg::NV_ADDR_W-1:0] mem_waddr;
  logic [7:0]                           mem_wdata;
  logic [eeprom_ctl_pkg::CTL_W-1:0]     ctrl_view;

  // Active data pointer chosen by the bank select bit
  assign active_ptr = s_reg.bank_sel ? s_reg.dp1 : s_reg.dp0;

  // Commit writes one buffered byte per cycle after the timed cycle
  assign mem_we    = (s_reg.state == eeprom_ctl_pkg::ST_COMMIT) &&
                     s_reg.buf_valid[s_reg.commit_idx] && s_reg.supply_s2;
  assign mem_waddr = {s_reg.buf_page, s_reg.commit_idx};
  assign mem_wdata = s_reg.buf_data[s_reg.commit_idx*8 +: 8];

  nv_byte_array u_cells (
    .ref_clk_in    (ref_clk_in),
    .write_en_in   (mem_we),
    .write_addr_in (mem_waddr),
    .write_data_in (mem_wdata),
    .read_addr_in  (active_ptr[eeprom_ctl_pkg::NV_ADDR_W-1:0]),
    .read_data_out (mem_rdata)
  );

  // Control register as software sees it; ready and supply are read-only
  always_comb begin
    ctrl_view = '0;
    ctrl_view[eeprom_ctl_pkg::CTL_PAGE_LOAD_BIT] = s_reg.page_load;
    ctrl_view[eeprom_ctl_pkg::CTL_WRITE_EN_BIT]  = s_reg.write_en;
    ctrl_view[eeprom_ctl_pkg::CTL_ONCHIP_BIT]    = s_reg.onchip_sel;
    ctrl_view[eeprom_ctl_pkg::CTL_BANK_BIT]      = s_reg.bank_sel;
    ctrl_view[eeprom_ctl_pkg::CTL_READY_BIT]     = s_reg.ready;
    ctrl_view[eeprom_ctl_pkg::CTL_SUPPLY_BIT]    = s_reg.supply_s2;
  end

  // Handshake outputs come straight from state
  assign move_ready_out    = !s_reg.pend;
  assign s_axi_awready_out = !s_reg.aw_full;
  assign s_axi_wready_out  = !s_reg.w_full;
  assign s_axi_arready_out = !s_reg.rvalid;
  assign s_axi_bvalid_out  = s_reg.bvalid;
  assign s_axi_bresp_out   = s_reg.bresp;
  assign s_axi_rvalid_out  = s_reg.rvalid;
  assign s_axi_rdata_out   = s_reg.axi_rdata;
  assign s_axi_rresp_out   = s_reg.rresp;
  assign move_ack_out      = s_reg.ack;
  assign move_rdata_out    = s_reg.rdata;
  assign ext_bus_out       = s_reg.ext;
  assign irq_out           = |(s_reg.irq_status & s_reg.irq_mask);

  // Next-state logic for the whole block
  always_comb begin
    logic                                  onchip;
    logic [eeprom_ctl_pkg::PAGE_OFF_W-1:0] off;
    logic [eeprom_ctl_pkg::PAGE_NUM_W-1:0] page;
    logic [eeprom_ctl_pkg::IRQ_W-1:0]      irq_set;
    logic [eeprom_ctl_pkg::IRQ_W-1:0]      irq_clr;
    logic                                  busy;
    onchip  = s_reg.onchip_sel && (active_ptr < eeprom_ctl_pkg::NV_BYTES);
    off     = active_ptr[eeprom_ctl_pkg::PAGE_OFF_W-1:0];
    page    = active_ptr[eeprom_ctl_pkg::NV_ADDR_W-1:eeprom_ctl_pkg::PAGE_OFF_W];
    irq_set = '0;
    irq_clr = '0;
    busy    = (s_reg.state != eeprom_ctl_pkg::ST_IDLE);
    s_next  = s_reg;
    s_next.supply_s1 = supply_ok_in;
    s_next.supply_s2 = s_reg.supply_s1;
    s_next.ack       = 1'b0;
    s_next.ext.req   = 1'b0;

    // Second stage of a move: answer with array data, the buffered byte with bit 7 inverted, or external data
    if (s_reg.pend) begin
      s_next.pend = 1'b0;
      s_next.ack  = 1'b1;
      if (!s_reg.pend_onchip) begin
        s_next.rdata = ext_rdata_in;
      end else if (s_reg.pend_inv) begin
        s_next.rdata = {~s_reg.pend_byte[7], s_reg.pend_byte[6:0]};
      end else begin
        s_next.rdata = mem_rdata;
      end
    end

    // First stage of a move; external accesses are forwarded as a pulse
    if (move_valid_in && !s_reg.pend) begin
      s_next.pend        = 1'b1;
      s_next.pend_onchip = onchip;
      s_next.pend_inv    = busy && (page == s_reg.buf_page) && s_reg.buf_valid[off];
      s_next.pend_byte   = s_reg.buf_data[off*8 +: 8];
      if (!onchip) begin
        s_next.ext.req   = 1'b1;
        s_next.ext.write = move_req_in.write;
        s_next.ext.addr  = active_ptr;
        s_next.ext.wdata = move_req_in.wdata;
      end else if (move_req_in.write) begin
        // Writing while disabled or busy would corrupt the page being programmed
        if (!s_reg.write_en || busy) begin
          irq_set[eeprom_ctl_pkg::IRQ_REFUSED_BIT] = 1'b1;
        end else begin
          // A byte for another page restarts the buffer on that page
          if (page != s_reg.buf_page) begin
            s_next.buf_valid = '0;
            s_next.buf_page  = page;
          end
          s_next.buf_valid[off]        = 1'b1;
          s_next.buf_data[off*8 +: 8]  = move_req_in.wdata;
          if (!s_reg.page_load) begin
            if (s_reg.supply_s2) begin
              s_next.state = eeprom_ctl_pkg::ST_ARM;
              s_next.timer = 32'(eeprom_ctl_pkg::START_DELAY_CYCLES - 1);
            end else begin
              irq_set[eeprom_ctl_pkg::IRQ_REFUSED_BIT] = 1'b1;
            end
          end
        end
      end
    end

    // Programming sequence: delay, one timed cycle for the page, then commit
    case (s_reg.state)
      eeprom_ctl_pkg::ST_IDLE: begin
      end
      eeprom_ctl_pkg::ST_ARM: begin
        if (s_reg.timer == 32'h0000_0000) begin
          s_next.state = eeprom_ctl_pkg::ST_PROGRAM;
          s_next.ready = 1'b0;
          s_next.timer = PROG_CYCLES - 1;
        end else begin
          s_next.timer = s_reg.timer - 32'h0000_0001;
        end
      end
      eeprom_ctl_pkg::ST_PROGRAM: begin
        if (s_reg.timer == 32'h0000_0000) begin
          s_next.state      = eeprom_ctl_pkg::ST_COMMIT;
          s_next.commit_idx = '0;
        end else begin
          s_next.timer = s_reg.timer - 32'h0000_0001;
        end
      end
      eeprom_ctl_pkg::ST_COMMIT: begin
        s_next.commit_idx = s_reg.commit_idx + 1'b1;
        if (s_reg.commit_idx == eeprom_ctl_pkg::PAGE_OFF_W'(eeprom_ctl_pkg::PAGE_BYTES - 1)) begin
          s_next.state     = eeprom_ctl_pkg::ST_IDLE;
          s_next.ready     = 1'b1;
          s_next.buf_valid = '0;
          irq_set[eeprom_ctl_pkg::IRQ_DONE_BIT] = 1'b1;
        end
      end
      default: begin
        s_next.state = eeprom_ctl_pkg::ST_IDLE;
      end
    endcase

    // Supply dip ends any cycle at once; the buffered page is dropped
    if (busy && !s_reg.supply_s2) begin
      s_next.state     = eeprom_ctl_pkg::ST_IDLE;
      s_next.ready     = 1'b1;
      s_next.buf_valid = '0;
      irq_set[eeprom_ctl_pkg::IRQ_ABORT_BIT] = 1'b1;
    end

    // AXI4-Lite write address and data are held independently
    if (s_axi_awvalid_in && !s_reg.aw_full) begin
      s_next.aw_full = 1'b1;
      s_next.aw_addr = s_axi_awaddr_in[7:0];
    end
    if (s_axi_wvalid_in && !s_reg.w_full) begin
      s_next.w_full = 1'b1;
      s_next.w_data = s_axi_wdata_in;
      s_next.w_strb = s_axi_wstrb_in;
    end
    if (s_reg.bvalid && s_axi_bready_in) begin
      s_next.bvalid = 1'b0;
    end
    // Perform the write once both halves are held and no response is pending
    if (s_reg.aw_full && s_reg.w_full && !s_reg.bvalid) begin
      s_next.aw_full = 1'b0;
      s_next.w_full  = 1'b0;
      s_next.bvalid  = 1'b1;
      s_next.bresp   = eeprom_ctl_pkg::RESP_OKAY;
      case (s_reg.aw_addr)
        eeprom_ctl_pkg::OFS_CONTROL: begin
          if (s_reg.w_strb[0]) begin
            s_next.page_load  = s_reg.w_data[eeprom_ctl_pkg::CTL_PAGE_LOAD_BIT];
            s_next.write_en   = s_reg.w_data[eeprom_ctl_pkg::CTL_WRITE_EN_BIT];
            s_next.onchip_sel = s_reg.w_data[eeprom_ctl_pkg::CTL_ONCHIP_BIT];
            s_next.bank_sel   = s_reg.w_data[eeprom_ctl_pkg::CTL_BANK_BIT];
          end
        end
        eeprom_ctl_pkg::OFS_PTR_ZERO: begin
          if (s_reg.w_strb[0]) s_next.dp0[7:0]  = s_reg.w_data[7:0];
          if (s_reg.w_strb[1]) s_next.dp0[15:8] = s_reg.w_data[15:8];
        end
        eeprom_ctl_pkg::OFS_PTR_ONE: begin
          if (s_reg.w_strb[0]) s_next.dp1[7:0]  = s_reg.w_data[7:0];
          if (s_reg.w_strb[1]) s_next.dp1[15:8] = s_reg.w_data[15:8];
        end
        eeprom_ctl_pkg::OFS_IRQ_STAT: begin
          if (s_reg.w_strb[0]) irq_clr = s_reg.w_data[eeprom_ctl_pkg::IRQ_W-1:0];
        end
        eeprom_ctl_pkg::OFS_IRQ_MASK: begin
          if (s_reg.w_strb[0]) s_next.irq_mask = s_reg.w_data[eeprom_ctl_pkg::IRQ_W-1:0];
        end
        default: begin
          s_next.bresp = eeprom_ctl_pkg::RESP_SLVERR;
        end
      endcase
    end

    // Read answers one cycle after the address is taken
    if (s_reg.rvalid && s_axi_rready_in) begin
      s_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid_in && !s_reg.rvalid) begin
      s_next.rvalid    = 1'b1;
      s_next.rresp     = eeprom_ctl_pkg::RESP_OKAY;
      s_next.axi_rdata = 32'h0000_0000;
      case (s_axi_araddr_in[7:0])
        eeprom_ctl_pkg::OFS_CONTROL:  s_next.axi_rdata[eeprom_ctl_pkg::CTL_W-1:0] = ctrl_view;
        eeprom_ctl_pkg::OFS_PTR_ZERO: s_next.axi_rdata[15:0] = s_reg.dp0;
        eeprom_ctl_pkg::OFS_PTR_ONE:  s_next.axi_rdata[15:0] = s_reg.dp1;
        eeprom_ctl_pkg::OFS_IRQ_STAT: begin
          s_next.axi_rdata[eeprom_ctl_pkg::IRQ_W-1:0] = s_reg.irq_status;
        end
        eeprom_ctl_pkg::OFS_IRQ_MASK: begin
          s_next.axi_rdata[eeprom_ctl_pkg::IRQ_W-1:0] = s_reg.irq_mask;
        end
        default: s_next.rresp = eeprom_ctl_pkg::RESP_SLVERR;
      endcase
    end

    // A new event wins over a clear in the same cycle
    s_next.irq_status = (s_reg.irq_status & ~irq_clr) | irq_set;
  end

  // All state registers in one process
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      s_reg       <= '0;
      s_reg.state <= eeprom_ctl_pkg::ST_IDLE;
      s_reg.ready <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end
endmodule

// ### logic/eeprom_ctl_pkg.sv
// Constants and carrier types for the data EEPROM access control block
package eeprom_ctl_pkg;
  // Array geometry
  localparam int NV_BYTES   = 2048;
  localparam int NV_ADDR_W  = 11;
  localparam int PAGE_BYTES = 32;
  localparam int PAGE_OFF_W = 5;
  localparam int PAGE_NUM_W = 6;
  localparam int PTR_W      = 16;

  // Programming time and its cycle count at the core clock
  localparam int unsigned CLK_FREQ_MHZ        = 100;
  localparam int unsigned PROG_TIME_US        = 4000;
  localparam int unsigned PROG_CYCLES_DEFAULT = PROG_TIME_US * CLK_FREQ_MHZ;
  // Delay from the final move to the ready flag dropping
  localparam int unsigned START_DELAY_CYCLES  = 4;

  // Control register bit positions
  localparam int CTL_PAGE_LOAD_BIT = 5;
  localparam int CTL_WRITE_EN_BIT  = 4;
  localparam int CTL_ONCHIP_BIT    = 3;
  localparam int CTL_BANK_BIT      = 2;
  localparam int CTL_READY_BIT     = 1;
  localparam int CTL_SUPPLY_BIT    = 0;
  localparam int CTL_W             = 8;

  // Register byte offsets on the AXI4-Lite bus
  localparam logic [7:0] OFS_CONTROL  = 8'h00;
  localparam logic [7:0] OFS_PTR_ZERO = 8'h04;
  localparam logic [7:0] OFS_PTR_ONE  = 8'h08;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h0C;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h10;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Interrupt status bits
  localparam int IRQ_DONE_BIT    = 0;
  localparam int IRQ_ABORT_BIT   = 1;
  localparam int IRQ_REFUSED_BIT = 2;
  localparam int IRQ_W           = 3;

  typedef enum {ST_IDLE, ST_ARM, ST_PROGRAM, ST_COMMIT} nv_state_type;

  // Move request from the core; address comes from the active pointer
  typedef struct packed {
    logic       write;
    logic [7:0] wdata;
  } move_req_type;

  // Forwarded access to external data memory
  typedef struct packed {
    logic             req;
    logic             write;
    logic [PTR_W-1:0] addr;
    logic [7:0]       wdata;
  } ext_bus_type;
endpackage

// ### logic/nv_byte_array.sv
// Byte array that stands in for the nonvolatile data cells
`timescale 1ns/1ps
module nv_byte_array (
  input  wire logic                                 ref_clk_in,
  input  wire logic                                 write_en_in,
  input  wire logic [eeprom_ctl_pkg::NV_ADDR_W-1:0] write_addr_in,
  input  wire logic [7:0]                           write_data_in,
  input  wire logic [eeprom_ctl_pkg::NV_ADDR_W-1:0] read_addr_in,
  output logic      [7:0]                           read_data_out
);
  logic [7:0] cells [eeprom_ctl_pkg::NV_BYTES];

  // Cells keep contents over reset, as nonvolatile storage must
  always_ff @(posedge ref_clk_in) begin
    if (write_en_in) begin
      cells[write_addr_in] <= write_data_in;
    end
    read_data_out <= cells[read_addr_in];
  end
endmodule

// ### tb/eeprom_ctl_assertions.sv
// Port-level assertions for the data EEPROM access control block
`timescale 1ns/1ps
module eeprom_ctl_assertions (
  input wire logic                        ref_clk_in,
  input wire logic                        reset_in,
  input wire logic                        s_axi_awready_out,
  input wire logic                        s_axi_wready_out,
  input wire logic                        s_axi_bvalid_out,
  input wire logic                        s_axi_bready_in,
  input wire logic [1:0]                  s_axi_bresp_out,
  input wire logic                        s_axi_arvalid_in,
  input wire logic                        s_axi_arready_out,
  input wire logic                        s_axi_rvalid_out,
  input wire logic                        s_axi_rready_in,
  input wire logic [31:0]                 s_axi_rdata_out,
  input wire logic                        move_valid_in,
  input wire logic                        move_ready_out,
  input wire logic                        move_ack_out,
  input wire eeprom_ctl_pkg::ext_bus_type ext_bus_out
);
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (reset_in);

  // A move is taken, then the port rests one cycle before the next
  sequence s_take;
    move_valid_in && move_ready_out;
  endsequence
  sequence s_gap;
    !move_ready_out ##1 move_ready_out;
  endsequence

  a_move_gap: assert property (s_take |=> s_gap) else $error("move ready gap wrong");
  a_ack_timing: assert property (s_take |-> ##2 move_ack_out) else $error("ack late");
  a_ack_pulse: assert property (move_ack_out |=> !move_ack_out) else $error("ack held");
  a_ext_pulse: assert property (ext_bus_out.req |=> !ext_bus_out.req && move_ack_out)
    else $error("bad external pulse");
  a_ext_cause: assert property (ext_bus_out.req |-> $past(move_valid_in && move_ready_out))
    else $error("stray external request");
  a_read_answer: assert property (
    s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out) else $error("read answer late");
  a_read_hold: assert property (s_axi_rvalid_out && !s_axi_rready_in |=>
    s_axi_rvalid_out && $stable(s_axi_rdata_out)) else $error("read data dropped");
  a_resp_hold: assert property (s_axi_bvalid_out && !s_axi_bready_in |=>
    s_axi_bvalid_out && $stable(s_axi_bresp_out)) else $error("write response dropped");
  a_write_block: assert property ($rose(s_axi_bvalid_out) |->
    $past(!s_axi_awready_out && !s_axi_wready_out)) else $error("response before both halves");
endmodule

bind data_eeprom_access_control eeprom_ctl_assertions chk_u (
  .ref_clk_in(ref_clk_in), .reset_in(reset_in), .s_axi_awready_out(s_axi_awready_out),
  .s_axi_wready_out(s_axi_wready_out), .s_axi_bvalid_out(s_axi_bvalid_out),
  .s_axi_bready_in(s_axi_bready_in), .s_axi_bresp_out(s_axi_bresp_out),
  .s_axi_arvalid_in(s_axi_arvalid_in), .s_axi_arready_out(s_axi_arready_out),
  .s_axi_rvalid_out(s_axi_rvalid_out), .s_axi_rready_in(s_axi_rready_in),
  .s_axi_rdata_out(s_axi_rdata_out), .move_valid_in(move_valid_in),
  .move_ready_out(move_ready_out), .move_ack_out(move_ack_out), .ext_bus_out(ext_bus_out));

// ### tb/core_move_model.sv
// Core-side model: issues data moves and stands in for external data memory
`timescale 1ns/1ps
module core_move_model (
  input  wire logic                        ref_clk_in,
  input  wire logic                        move_ready_in,
  input  wire logic                        move_ack_in,
  input  wire logic [7:0]                  move_rdata_in,
  input  wire eeprom_ctl_pkg::ext_bus_type ext_bus_in,
  output logic                             move_valid_out,
  output eeprom_ctl_pkg::move_req_type     move_req_out,
  output logic      [7:0]                  ext_rdata_out
);
  logic [7:0] ext_mem [64];
  logic [7:0] idle_pat  = 8'h00;
  int         ext_count = 0;

  initial begin
    move_valid_out = 1'b0;
    move_req_out   = '0;
  end

  // Outside a request the data lines wander, so stale data never looks valid
  assign ext_rdata_out = ext_bus_in.req ? ext_mem[ext_bus_in.addr[5:0]] : idle_pat;

  // External memory stores forwarded writes and counts every access
  always @(posedge ref_clk_in) begin
    idle_pat <= idle_pat + 8'h3B;
    if (ext_bus_in.req) begin
      ext_count <= ext_count + 1;
      if (ext_bus_in.write) ext_mem[ext_bus_in.addr[5:0]] <= ext_bus_in.wdata;
    end
  end

  // One move: request held until taken, then wait for the acknowledge
  task automatic move(input logic wr, input logic [7:0] d, output logic [7:0] q,
                      output logic ok);
    logic took = 1'b0;
    ok = 1'b0;
    @(posedge ref_clk_in);
    move_valid_out <= 1'b1;
    move_req_out   <= '{write: wr, wdata: d};
    for (int i = 0; i < 20 && !took; i++) begin
      @(posedge ref_clk_in);
      took = move_ready_in;
    end
    move_valid_out <= 1'b0;
    for (int i = 0; i < 8 && took && !ok; i++) begin
      @(posedge ref_clk_in);
      ok = move_ack_in;
    end
    q = move_rdata_in;
  endtask
endmodule

// ### tb/data_eeprom_access_control_bench.sv
// Self-checking bench for the data EEPROM access control block
`timescale 1ns/1ps
module data_eeprom_access_control_bench;
  logic ref_clk_in = 1'b0, reset_in = 1'b1, supply_ok = 1'b1;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata, q;
  logic awready, wready, bvalid, arready, rvalid, mv_valid, mv_ready, mv_ack, irq, ok;
  logic [1:0] bresp, rresp, r;
  logic [7:0] mv_rdata, ext_rdata, mq, b;
  logic [7:0] pg [4];
  eeprom_ctl_pkg::move_req_type mv_req;
  eeprom_ctl_pkg::ext_bus_type  ext_bus;
  int err_count = 0, total_checks = 0, n;

  // Short program time keeps the run brief
  data_eeprom_access_control #(.PROG_CYCLES(20)) dut_u (
    .ref_clk_in(ref_clk_in), .reset_in(reset_in), .s_axi_awvalid_in(awvalid),
    .s_axi_awready_out(awready), .s_axi_awaddr_in(awaddr), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF),
    .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready), .s_axi_bresp_out(bresp),
    .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready), .s_axi_araddr_in(araddr),
    .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp), .move_valid_in(mv_valid), .move_ready_out(mv_ready),
    .move_req_in(mv_req), .move_ack_out(mv_ack), .move_rdata_out(mv_rdata),
    .ext_bus_out(ext_bus), .ext_rdata_in(ext_rdata), .supply_ok_in(supply_ok), .irq_out(irq));

  core_move_model core_u (
    .ref_clk_in(ref_clk_in), .move_ready_in(mv_ready), .move_ack_in(mv_ack),
    .move_rdata_in(mv_rdata), .ext_bus_in(ext_bus), .move_valid_out(mv_valid),
    .move_req_out(mv_req), .ext_rdata_out(ext_rdata));

  always #5 ref_clk_in = ~ref_clk_in;

  // Verdict and run end, shared with every timeout
  task automatic give_verdict();
    $display("checks=%0d mismatches=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tmo();
    check(32'h0, 32'h1);
    give_verdict();
  endtask

  // Register write: address and data offered together, each released once taken
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    logic ad = 1'b0, wd = 1'b0;
    @(posedge ref_clk_in);
    awvalid <= 1'b1;
    awaddr  <= {24'h0, a};
    wvalid  <= 1'b1;
    wdata   <= d;
    for (int i = 0; i < 40 && !(ad && wd); i++) begin
      @(posedge ref_clk_in);
      ad = ad | awready;
      wd = wd | wready;
      awvalid <= !ad;
      wvalid  <= !wd;
    end
    for (int i = 0; i < 40 && !bvalid; i++) @(posedge ref_clk_in);
    if (!bvalid) tmo();
    bready <= 1'b1;
    @(posedge ref_clk_in);
    r = bresp;
    bready <= 1'b0;
  endtask

  // Register read: result lands in q and r
  task automatic rreg(input logic [7:0] a);
    @(posedge ref_clk_in);
    arvalid <= 1'b1;
    araddr  <= {24'h0, a};
    rready  <= 1'($urandom);
    for (int i = 0; i < 40; i++) begin
      @(posedge ref_clk_in);
      if (arready) break;
    end
    arvalid <= 1'b0;
    for (int i = 0; i < 40 && !rvalid; i++) @(posedge ref_clk_in);
    if (!rvalid) tmo();
    if (!rready) rready <= 1'b1;
    if (!rready) @(posedge ref_clk_in); // Still the old value, so one more edge
    q = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  // Move through pointer bank one
  task automatic at(input logic [15:0] a, input logic wr, input logic [7:0] d);
    wreg(eeprom_ctl_pkg::OFS_PTR_ONE, {16'h0, a});
    core_u.move(wr, d, mq, ok);
    if (!ok) tmo();
  endtask

  // Ready is never trusted right after the move; polling is bounded
  task automatic poll(input logic want, input int lim);
    n = 0;
    do begin
      rreg(eeprom_ctl_pkg::OFS_CONTROL);
      n++;
    end while (q[1] !== want && n < lim);
  endtask

  initial begin
    void'($urandom(32'hF110));
    repeat (16) @(posedge ref_clk_in);
    reset_in <= 1'b0;
    repeat (3) @(posedge ref_clk_in);
    // Reset value, hardware-owned bits and an unmapped offset
    rreg(eeprom_ctl_pkg::OFS_CONTROL);
    check(q, 32'h03);
    wreg(eeprom_ctl_pkg::OFS_CONTROL, 32'hFF);
    rreg(eeprom_ctl_pkg::OFS_CONTROL);
    check(q, 32'h3F);
    rreg(8'h14);
    check(r, eeprom_ctl_pkg::RESP_SLVERR);
    wreg(8'h14, 32'h0);
    check(r, eeprom_ctl_pkg::RESP_SLVERR);
    $display("test registers done");
    // Routing by select bit, address range and pointer bank
    wreg(eeprom_ctl_pkg::OFS_PTR_ZERO, 32'h0900);
    wreg(eeprom_ctl_pkg::OFS_PTR_ONE, 32'h0010);
    for (int k = 0; k < 4; k++) begin
      n = core_u.ext_count;
      b = 8'($urandom);
      wreg(eeprom_ctl_pkg::OFS_CONTROL, 32'(k * 4));
      core_u.move(k < 3, b, mq, ok);
      check(32'(core_u.ext_count - n), {31'h0, k < 3});
      if (k < 3) check(core_u.ext_mem[(k == 1) ? 16 : 0], b);
    end
    wreg(eeprom_ctl_pkg::OFS_CONTROL, 32'h00);
    core_u.move(1'b0, 8'h00, mq, ok);
    check(mq, core_u.ext_mem[0]);
    $display("test routing done");
    // Page mode: loads leave the flag ready, the final write programs the page
    wreg(eeprom_ctl_pkg::OFS_CONTROL, 32'h3C);
    for (int k = 0; k < 4; k++) begin
      pg[k] = 8'($urandom);
      if (k == 3) rreg(eeprom_ctl_pkg::OFS_CONTROL);
      if (k == 3) check(q[1], 1'b1);
      if (k == 3) wreg(eeprom_ctl_pkg::OFS_CONTROL, 32'h1C);
      at(16'h0040 + 16'(k), 1'b1, pg[k]);
    end
    poll(1'b0, 40);
    check(q[1], 1'b0);
    at(16'h0041, 1'b0, 8'h00);
    check(mq, pg[1] ^ 8'h80);
    poll(1'b1, 200);
    check(q[1], 1'b1);
    check(32'(n < 30), 32'h1);
    for (int k = 0; k < 4; k++) begin
      at(16'h0040 + 16'(k), 1'b0, 8'h00);
      check(mq, pg[k]);
    end
    rreg(eeprom_ctl_pkg::OFS_IRQ_STAT);
    check(q, 32'h1);
    wreg(eeprom_ctl_pkg::OFS_IRQ_MASK, 32'h1);
    repeat (2) @(posedge ref_clk_in);
    check(irq, 1'b1);
    wreg(eeprom_ctl_pkg::OFS_IRQ_STAT, 32'h1);
    repeat (2) @(posedge ref_clk_in);
    check(irq, 1'b0);
    wreg(eeprom_ctl_pkg::OFS_CONTROL, 32'h0C);
    $display("test page program done");
    // Write without write enable is refused and flagged
    at(16'h0040, 1'b1, ~pg[0]);
    rreg(eeprom_ctl_pkg::OFS_CONTROL);
    check(q[1], 1'b1);
    at(16'h0040, 1'b0, 8'h00);
    check(mq, pg[0]);
    check(irq, 1'b0);
    wreg(eeprom_ctl_pkg::OFS_IRQ_MASK, 32'h4);
    repeat (2) @(posedge ref_clk_in);
    check(irq, 1'b1);
    wreg(eeprom_ctl_pkg::OFS_IRQ_STAT, 32'h4);
    $display("test refused write done");
    // Low supply blocks a new cycle, then aborts a running one
    @(posedge ref_clk_in);
    supply_ok <= 1'b0;
    wreg(eeprom_ctl_pkg::OFS_CONTROL, 32'h1C);
    rreg(eeprom_ctl_pkg::OFS_CONTROL);
    check(q[1:0], 2'b10);
    at(16'h0040, 1'b1, ~pg[0]);
    poll(1'b0, 4);
    check(q[1], 1'b1);
    supply_ok <= 1'b1;
    repeat (4) @(posedge ref_clk_in);
    at(16'h0040, 1'b1, ~pg[0]);
    poll(1'b0, 40);
    supply_ok <= 1'b0;
    poll(1'b1, 40);
    check(q[1], 1'b1);
    rreg(eeprom_ctl_pkg::OFS_IRQ_STAT);
    check(q[1], 1'b1);
    supply_ok <= 1'b1;
    at(16'h0040, 1'b0, 8'h00);
    check(mq, pg[0]);
    $display("test low supply done");
    give_verdict();
  end
endmodule
